// *** rtl/npb_pkg.sv ***
// constants and types for the flash protection and boot configuration block
package npb_pkg;

  // register indices; byte address is four times the index
  localparam logic [3:0] IDX_LATCH0    = 4'h0; // port drive modes 0..3
  localparam logic [3:0] IDX_LATCH1    = 4'h1; // port drive modes 4,5,6,12
  localparam logic [3:0] IDX_LATCH2    = 4'h2; // reset pin, port 15 mode
  localparam logic [3:0] IDX_LATCH3    = 4'h3; // boot, debug, ecc, phase
  localparam logic [3:0] IDX_CTRL      = 4'h4; // command strobes
  localparam logic [3:0] IDX_STATUS    = 4'h5; // state and sticky errors
  localparam logic [3:0] IDX_PROT_ROW  = 4'h6; // selected flash row
  localparam logic [3:0] IDX_PROT_LVL  = 4'h7; // level of selected row
  localparam logic [3:0] IDX_EE_ADDR   = 4'h8; // eeprom byte address
  localparam logic [3:0] IDX_EE_DATA   = 4'h9; // direct eeprom byte read
  localparam logic [3:0] IDX_EE_BUF    = 4'ha; // row buffer byte write

  // command bits of the control register
  localparam int CTRL_ERASE  = 0; // complete flash erase
  localparam int CTRL_LOCK   = 1; // close protection changes
  localparam int CTRL_SECURE = 2; // engage device security
  localparam int CTRL_EE_WR  = 3; // write row buffer to eeprom row

  // status bits
  localparam int ST_OPEN     = 0;
  localparam int ST_SECURE   = 1;
  localparam int ST_EE_BUSY  = 2;
  localparam int ST_PROT_ERR = 3;
  localparam int ST_EE_ERR   = 4;

  // latch field positions
  localparam int L2_RESET_PIN = 7;
  localparam int L3_SPEED     = 0;
  localparam int L3_DPS_LO    = 1;
  localparam int L3_ECC       = 3;
  localparam int L3_PHASE_LO  = 4;

  // factory defaults of the latches
  localparam logic [7:0] LATCH0_RST = 8'h00;
  localparam logic [7:0] LATCH1_RST = 8'h00;
  localparam logic [7:0] LATCH3_RST = 8'h0a; // ecc on, 4-wire jtag, 12 mhz

  // flash and eeprom geometry
  localparam int FLASH_ROW_BYTES  = 256;
  localparam int FLASH_SPARE_BYTES = 32;
  localparam int FLASH_ROWS       = 256;
  localparam int EE_ROWS          = 128;
  localparam int EE_ROW_BYTES     = 16;
  localparam int EE_BYTES         = EE_ROWS * EE_ROW_BYTES;
  localparam logic [1:0] DBG_OFF  = 2'h3;

  // protection levels, lowest to highest
  typedef enum logic [1:0] {
    LVL_OPEN,
    LVL_FACTORY,
    LVL_FIELD,
    LVL_FULL
  } npb_level_t;

endpackage : npb_pkg

// *** rtl/npb_top.sv ***
// flash protection, eeprom access and config latch logic
`timescale 1ns/1ps
module npb_top #(
  parameter logic RESET_PIN_DEFAULT = 1'b0 // depends on package size
) (
  input  wire logic        CLK,             // system clock, 20 mhz
  input  wire logic        RESET_N,         // async reset, active low
  input  wire logic [5:0]  AVS_ADDRESS,     // byte address
  input  wire logic        AVS_READ,        // read request
  input  wire logic        AVS_WRITE,       // write request
  input  wire logic [31:0] AVS_WRITEDATA,   // write data
  input  wire logic [3:0]  AVS_BYTEENABLE,  // byte lanes
  output logic      [31:0] AVS_READDATA,    // read data
  output logic             AVS_WAITREQUEST, // stall
  input  wire logic        ACC_REQ,         // flash access request
  input  wire logic        ACC_EXT,         // 1 external, 0 internal
  input  wire logic        ACC_WR,          // 1 write, 0 read
  input  wire logic [15:0] ACC_ADDR,        // flash byte address
  input  wire logic [7:0]  FLASH_RDATA,     // raw flash byte
  output logic             ACC_DONE,        // access answered
  output logic             ACC_GRANT,       // access allowed
  output logic [7:0]       ACC_RDATA,       // gated read byte
  output logic             FLASH_WR_STB,    // allowed flash write
  output logic [17:0]      PORT_DRIVE_MODE, // ports 0-6,12,15
  output logic             RESET_PIN_SEL,   // 1 external reset input
  output logic             BOOT_CLK_FAST,   // 1 48 mhz boot clock
  output logic [1:0]       DEBUG_PORT_SEL,  // debug port mode
  output logic             ECC_ENABLE,      // spare area as ecc
  output logic [3:0]       DIG_PHASE_DELAY, // clock phase delay
  output logic             TEST_PORT_EN     // test ports usable
);

  ////////////////////////////////////////////////////////////////////////
  // declarations

  logic [7:0]          latch_q [4];
  npb_pkg::npb_level_t prot_q [npb_pkg::FLASH_ROWS];
  logic [7:0]          ee_mem_q [npb_pkg::EE_BYTES];
  logic [7:0]          ee_buf_q [npb_pkg::EE_ROW_BYTES];
  logic [7:0]          prot_row_q;
  logic [10:0]         ee_addr_q;
  logic                prot_open_q;
  logic                secure_q;
  logic                prot_err_q;
  logic                ee_err_q;
  logic                ee_busy_q;
  logic [3:0]          ee_cnt_q;
  logic [6:0]          ee_row_q;
  logic                boot_q;
  logic                req;
  logic                take;
  logic                wr_en;
  logic [3:0]          idx;
  logic                mapped;
  logic [31:0]         rdata_d;
  logic [7:0]          wbyte;
  logic                cmd_erase;
  logic                cmd_lock;
  logic                cmd_secure;
  logic                cmd_ee_wr;
  logic                wr_prot;
  logic                ee_start;
  npb_pkg::npb_level_t cur_lvl;
  npb_pkg::npb_level_t acc_lvl;
  logic                allow;

  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RESET_N);

  ////////////////////////////////////////////////////////////////////////
  // avalon slave: one wait state, answer while waitrequest is low

  assign req   = AVS_READ | AVS_WRITE;
  assign take  = req & ~AVS_WAITREQUEST;
  assign wr_en = take & AVS_WRITE & AVS_BYTEENABLE[0];
  assign idx   = AVS_ADDRESS[5:2];
  assign wbyte = AVS_WRITEDATA[7:0];

  // waitrequest drops for exactly the accepting cycle
  always_ff @(posedge CLK or negedge RESET_N)
  begin
    if (!RESET_N)
      AVS_WAITREQUEST <= 1'b1;
    else
      AVS_WAITREQUEST <= ~(req & AVS_WAITREQUEST);
  end

  a_wait_one: assert property (req && AVS_WAITREQUEST |=> !AVS_WAITREQUEST)
    else $error("bus request not answered after one wait state");

  // read mux, unmapped addresses read as zero
  always_comb
  begin
    rdata_d = 32'h0000_0000;
    mapped  = 1'b1;
    if (AVS_ADDRESS[1:0] != 2'h0)
      mapped = 1'b0;
    else if (idx <= npb_pkg::IDX_LATCH3)
      rdata_d[7:0] = latch_q[idx[1:0]];
    else if (idx == npb_pkg::IDX_STATUS)
    begin
      rdata_d[npb_pkg::ST_OPEN]     = prot_open_q;
      rdata_d[npb_pkg::ST_SECURE]   = secure_q;
      rdata_d[npb_pkg::ST_EE_BUSY]  = ee_busy_q;
      rdata_d[npb_pkg::ST_PROT_ERR] = prot_err_q;
      rdata_d[npb_pkg::ST_EE_ERR]   = ee_err_q;
    end
    else if (idx == npb_pkg::IDX_PROT_ROW)
      rdata_d[7:0] = prot_row_q;
    else if (idx == npb_pkg::IDX_PROT_LVL)
      rdata_d[1:0] = cur_lvl;
    else if (idx == npb_pkg::IDX_EE_ADDR)
      rdata_d[10:0] = ee_addr_q;
    else if (idx == npb_pkg::IDX_EE_DATA)
      rdata_d[7:0] = ee_mem_q[ee_addr_q];
    else if (idx == npb_pkg::IDX_CTRL || idx == npb_pkg::IDX_EE_BUF)
      rdata_d = 32'h0000_0000;
    else
      mapped = 1'b0;
  end

  // read data captured in the cycle that waitrequest falls
  always_ff @(posedge CLK or negedge RESET_N)
  begin
    if (!RESET_N)
      AVS_READDATA <= 32'h0000_0000;
    else if (req && AVS_WAITREQUEST)
      AVS_READDATA <= mapped ? rdata_d : 32'h0000_0000;
  end

  a_ee_read_direct: assert property (take && AVS_READ && mapped &&
      idx == npb_pkg::IDX_EE_DATA |-> AVS_READDATA[7:0] ==
      ee_mem_q[ee_addr_q])
    else $error("eeprom byte read does not match storage");

  ////////////////////////////////////////////////////////////////////////
  // write decode

  assign cmd_erase  = wr_en && mapped && idx == npb_pkg::IDX_CTRL &&
                      wbyte[npb_pkg::CTRL_ERASE];
  assign cmd_lock   = wr_en && mapped && idx == npb_pkg::IDX_CTRL &&
                      wbyte[npb_pkg::CTRL_LOCK];
  assign cmd_secure = wr_en && mapped && idx == npb_pkg::IDX_CTRL &&
                      wbyte[npb_pkg::CTRL_SECURE];
  assign cmd_ee_wr  = wr_en && mapped && idx == npb_pkg::IDX_CTRL &&
                      wbyte[npb_pkg::CTRL_EE_WR];
  assign wr_prot    = wr_en && mapped && idx == npb_pkg::IDX_PROT_LVL;
  assign ee_start   = cmd_ee_wr & ~ee_busy_q;
  assign cur_lvl    = prot_q[prot_row_q];

  // config latches, volatile, factory values reloaded at every reset
  // factory reset pin use ready before boot
  always_ff @(posedge CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      latch_q[0] <= npb_pkg::LATCH0_RST;
      latch_q[1] <= npb_pkg::LATCH1_RST;
      latch_q[2] <= {RESET_PIN_DEFAULT, 7'h00};
      latch_q[3] <= npb_pkg::LATCH3_RST;
    end
    else if (wr_en && mapped && idx <= npb_pkg::IDX_LATCH3)
      latch_q[idx[1:0]] <= wbyte;
  end

  // selection registers
  always_ff @(posedge CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      prot_row_q <= 8'h00;
      ee_addr_q  <= 11'h000;
    end
    else if (wr_en && mapped && idx == npb_pkg::IDX_PROT_ROW)
      prot_row_q <= wbyte;
    else if (wr_en && mapped && idx == npb_pkg::IDX_EE_ADDR)
      ee_addr_q <= AVS_WRITEDATA[10:0];
  end

  ////////////////////////////////////////////////////////////////////////
  // protection table and security

  always_ff @(posedge CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      for (int i = 0; i < npb_pkg::FLASH_ROWS; i++)
        prot_q[i] <= npb_pkg::LVL_OPEN;
    end
    else if (cmd_erase)
    begin
      for (int i = 0; i < npb_pkg::FLASH_ROWS; i++)
        prot_q[i] <= npb_pkg::LVL_OPEN;
    end
    else if (wr_prot && prot_open_q)
      prot_q[prot_row_q] <= npb_pkg::npb_level_t'(wbyte[1:0]);
  end

  // erase opens protection changes, lock closes them
  always_ff @(posedge CLK or negedge RESET_N)
  begin
    if (!RESET_N)
      prot_open_q <= 1'b0;
    else if (cmd_erase)
      prot_open_q <= 1'b1;
    else if (cmd_lock)
      prot_open_q <= 1'b0;
  end

  a_prot_locked: assert property (wr_prot && !prot_open_q && !cmd_erase
      |=> cur_lvl == $past(cur_lvl))
    else $error("protection level changed without erase");

  // sticky errors, set wins over write-one clear
  always_ff @(posedge CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      prot_err_q <= 1'b0;
      ee_err_q   <= 1'b0;
    end
    else
    begin
      if (wr_prot && !prot_open_q)
        prot_err_q <= 1'b1;
      else if (wr_en && mapped && idx == npb_pkg::IDX_STATUS &&
               wbyte[npb_pkg::ST_PROT_ERR])
        prot_err_q <= 1'b0;
      if (cmd_ee_wr && ee_busy_q)
        ee_err_q <= 1'b1;
      else if (wr_en && mapped && idx == npb_pkg::IDX_STATUS &&
               wbyte[npb_pkg::ST_EE_ERR])
        ee_err_q <= 1'b0;
    end
  end

  // security sets once, no clear path
  always_ff @(posedge CLK or negedge RESET_N)
  begin
    if (!RESET_N)
      secure_q <= 1'b0;
    else if (cmd_secure)
      secure_q <= 1'b1;
  end

  a_secure_sticky: assert property (secure_q |=> secure_q &&
      DEBUG_PORT_SEL == npb_pkg::DBG_OFF && !TEST_PORT_EN)
    else $error("secured device reopened a debug port");

  ////////////////////////////////////////////////////////////////////////
  // flash access check

  // row is the upper address byte
  assign acc_lvl = prot_q[ACC_ADDR[15:8]];

  always_comb
  begin
    allow = 1'b0;
    case (acc_lvl)
      npb_pkg::LVL_OPEN:    allow = 1'b1;
      npb_pkg::LVL_FACTORY: allow = ~ACC_EXT | ACC_WR;
      npb_pkg::LVL_FIELD:   allow = ~ACC_EXT;
      npb_pkg::LVL_FULL:    allow = ~ACC_EXT & ~ACC_WR;
      default:              allow = 1'b0;
    endcase
    if (secure_q && ACC_EXT)
      allow = 1'b0;
  end

  // eeprom activity never stalls this path
  // denied write gives no strobe, denied read gives zero
  always_ff @(posedge CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      ACC_DONE     <= 1'b0;
      ACC_GRANT    <= 1'b0;
      ACC_RDATA    <= 8'h00;
      FLASH_WR_STB <= 1'b0;
    end
    else
    begin
      ACC_DONE     <= ACC_REQ;
      ACC_GRANT    <= ACC_REQ & allow;
      ACC_RDATA    <= (ACC_REQ && allow && !ACC_WR) ? FLASH_RDATA : 8'h00;
      FLASH_WR_STB <= ACC_REQ & allow & ACC_WR;
    end
  end

  a_field_ext_deny: assert property (ACC_REQ && ACC_EXT &&
      acc_lvl == npb_pkg::LVL_FIELD |=> ACC_DONE && !ACC_GRANT)
    else $error("external access granted on field-upgrade row");

  a_full_wr_deny: assert property (ACC_REQ && ACC_WR &&
      acc_lvl == npb_pkg::LVL_FULL |=> !ACC_GRANT && !FLASH_WR_STB)
    else $error("write granted on fully protected row");

  a_denied_nodata: assert property (ACC_DONE && !ACC_GRANT
      |-> ACC_RDATA == 8'h00 && !FLASH_WR_STB)
    else $error("denied access leaked data or wrote flash");

  a_flash_runs: assert property (ee_busy_q && ACC_REQ && !ACC_EXT &&
      !ACC_WR |=> ACC_DONE && ACC_GRANT)
    else $error("flash read stalled during eeprom write");

  ////////////////////////////////////////////////////////////////////////
  // eeprom row buffer and row writer

  // buffer byte lands at the low nibble of the eeprom address
  always_ff @(posedge CLK)
  begin
    if (wr_en && mapped && idx == npb_pkg::IDX_EE_BUF)
      ee_buf_q[ee_addr_q[3:0]] <= wbyte;
  end

  // whole row replaced, one byte per clock
  always_ff @(posedge CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      ee_busy_q <= 1'b0;
      ee_cnt_q  <= 4'h0;
      ee_row_q  <= 7'h00;
    end
    else if (ee_start)
    begin
      ee_busy_q <= 1'b1;
      ee_cnt_q  <= 4'h0;
      ee_row_q  <= ee_addr_q[10:4];
    end
    else if (ee_busy_q)
    begin
      ee_cnt_q <= ee_cnt_q + 4'h1;
      if (ee_cnt_q == 4'hf)
        ee_busy_q <= 1'b0;
    end
  end

  // data store only, no check bits
  always_ff @(posedge CLK)
  begin
    if (ee_busy_q)
      ee_mem_q[{ee_row_q, ee_cnt_q}] <= ee_buf_q[ee_cnt_q];
  end

  a_ee_row_len: assert property (ee_start |=> ##15 ee_busy_q ##1 !ee_busy_q)
    else $error("eeprom row write not sixteen cycles");

  ////////////////////////////////////////////////////////////////////////
  // boot configuration, applied once after reset release

  always_ff @(posedge CLK or negedge RESET_N)
  begin
    if (!RESET_N)
      boot_q <= 1'b1;
    else
      boot_q <= 1'b0;
  end

  always_ff @(posedge CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      PORT_DRIVE_MODE <= 18'h00000;
      RESET_PIN_SEL   <= 1'b0;
      BOOT_CLK_FAST   <= 1'b0;
      ECC_ENABLE      <= 1'b1;
      DIG_PHASE_DELAY <= 4'h0;
    end
    else if (boot_q)
    begin
      PORT_DRIVE_MODE <= {latch_q[2][1:0], latch_q[1], latch_q[0]};
      RESET_PIN_SEL   <= latch_q[2][npb_pkg::L2_RESET_PIN];
      BOOT_CLK_FAST   <= latch_q[3][npb_pkg::L3_SPEED];
      ECC_ENABLE      <= latch_q[3][npb_pkg::L3_ECC];
      DIG_PHASE_DELAY <= latch_q[3][npb_pkg::L3_PHASE_LO +: 4];
    end
  end

  always_ff @(posedge CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      DEBUG_PORT_SEL <= npb_pkg::DBG_OFF;
      TEST_PORT_EN   <= 1'b0;
    end
    else if (secure_q)
    begin
      DEBUG_PORT_SEL <= npb_pkg::DBG_OFF;
      TEST_PORT_EN   <= 1'b0;
    end
    else if (boot_q)
    begin
      DEBUG_PORT_SEL <= latch_q[3][npb_pkg::L3_DPS_LO +: 2];
      TEST_PORT_EN   <= 1'b1;
    end
  end

  a_boot_apply: assert property (boot_q |=> ECC_ENABLE ==
      $past(latch_q[3][npb_pkg::L3_ECC]) && BOOT_CLK_FAST ==
      $past(latch_q[3][npb_pkg::L3_SPEED]))
    else $error("boot did not apply config latches");

endmodule : npb_top

// *** test/npb_flash_model.sv ***
// flash array stand-in answering the flash access port
`timescale 1ns/1ps
module npb_flash_model (
  input  wire logic        clk,      // system clock
  input  wire logic        rst_n,    // async reset, active low
  input  wire logic        acc_req,  // access strobe
  input  wire logic [15:0] acc_addr, // flash byte address
  input  wire logic        wr_stb,   // granted write strobe
  output logic      [7:0]  rdata,    // raw flash byte
  output logic      [15:0] wr_cnt_q  // granted writes seen
);
  logic [7:0] last_q;

  ////////////////////////////////////////////////////////////////////////////
  // byte per address
  // address-derived byte while asked, churning pattern otherwise
  assign rdata = acc_req ? (acc_addr[7:0] ^ acc_addr[15:8] ^ 8'h3c) : last_q;

  // inverse of last value so a stale byte never matches
  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
      last_q <= 8'h00;
    else
      last_q <= ~rdata;

  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
      wr_cnt_q <= 16'h0000;
    else if (wr_stb)
      wr_cnt_q <= wr_cnt_q + 16'h0001;
endmodule : npb_flash_model

// *** test/tb_npb_top.sv ***
// self-checking bench for the protection and boot config block
`timescale 1ns/1ps
module tb_npb_top;
  logic        clk, reset_n, rd, wr, wait_req;
  logic [5:0]  addr;
  logic [31:0] wdata, rdata, q;
  logic [3:0]  be, phase;
  logic        acc_req, acc_ext, acc_wr, acc_done, acc_grant, wr_stb;
  logic [15:0] acc_addr, wr_cnt, exp_wr;
  logic [7:0]  fl_rdata, acc_rdata, g_rdata, e_rd;
  logic [17:0] pdm;
  logic [1:0]  dbg;
  logic        rst_sel, fast, ecc, test_en, g_done, g_grant, ok;
  int          error_cnt, n_compared;

  npb_top #(.RESET_PIN_DEFAULT(1'b1)) dut (.CLK(clk), .RESET_N(reset_n),
    .AVS_ADDRESS(addr),
    .AVS_READ(rd), .AVS_WRITE(wr), .AVS_WRITEDATA(wdata),
    .AVS_BYTEENABLE(be), .AVS_READDATA(rdata), .AVS_WAITREQUEST(wait_req),
    .ACC_REQ(acc_req), .ACC_EXT(acc_ext), .ACC_WR(acc_wr),
    .ACC_ADDR(acc_addr), .FLASH_RDATA(fl_rdata), .ACC_DONE(acc_done),
    .ACC_GRANT(acc_grant), .ACC_RDATA(acc_rdata), .FLASH_WR_STB(wr_stb),
    .PORT_DRIVE_MODE(pdm), .RESET_PIN_SEL(rst_sel), .BOOT_CLK_FAST(fast),
    .DEBUG_PORT_SEL(dbg), .ECC_ENABLE(ecc), .DIG_PHASE_DELAY(phase),
    .TEST_PORT_EN(test_en));

  npb_flash_model flash (.clk(clk), .rst_n(reset_n), .acc_req(acc_req),
    .acc_addr(acc_addr), .wr_stb(wr_stb), .rdata(fl_rdata),
    .wr_cnt_q(wr_cnt));

  ////////////////////////////////////////////////////////////////////////////
  // clock and hang guard
  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  initial
  begin
    repeat (5000) @(posedge clk);
    error_cnt++;
    end_sim();
  end

  ////////////////////////////////////////////////////////////////////////////
  // compare, bus and access tasks
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e)
    begin
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      error_cnt++;
    end
  endtask : chk

  // request held until waitrequest is sampled low
  task bus(input logic w, input logic [3:0] idx, input logic [31:0] d);
    @(posedge clk);
    addr  <= {idx, 2'b00};
    wdata <= d;
    rd    <= !w;
    wr    <= w;
    // no timeout here, a stuck waitrequest is ended only by the hang guard
    do
    begin
      @(posedge clk);
    end
    while (wait_req !== 1'b0);
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask : bus

  task wreg(input logic [3:0] idx, input logic [31:0] d);
    bus(1'b1, idx, d);
  endtask : wreg

  task rchk(input string nm, input logic [3:0] idx, input logic [31:0] e);
    bus(1'b0, idx, 32'h0);
    chk(nm, e, q);
  endtask : rchk

  // one access, answer sampled in the cycle it stands
  task acc(input logic ext, input logic w, input logic [15:0] a);
    @(posedge clk);
    acc_req  <= 1'b1;
    acc_ext  <= ext;
    acc_wr   <= w;
    acc_addr <= a;
    @(posedge clk);
    acc_req <= 1'b0;
    @(posedge clk);
    g_done  = acc_done;
    g_grant = acc_grant;
    g_rdata = acc_rdata;
  endtask : acc

  task end_sim();
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : end_sim

  ////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial
  begin
    reset_n = 1'b0;
    rd = 1'b0;
    wr = 1'b0;
    addr = 6'h00;
    wdata = 32'h0;
    be = 4'hf;
    acc_req = 1'b0;
    acc_ext = 1'b0;
    acc_wr = 1'b0;
    acc_addr = 16'h0000;
    error_cnt = 0;
    n_compared = 0;
    exp_wr = 16'h0;
    repeat (5) @(posedge clk);
    reset_n <= 1'b1;
    repeat (3) @(posedge clk);
    chk("drive_mode", 32'h0, pdm);
    chk("reset_pin", 32'h1, rst_sel);
    chk("boot_fast", 32'h0, fast);
    chk("debug_sel", 32'h1, dbg);
    chk("ecc_en", 32'h1, ecc);
    chk("phase", 32'h0, phase);
    chk("test_en", 32'h1, test_en);
    rchk("latch0", 4'h0, 32'h00);
    rchk("latch2", 4'h2, 32'h80);
    rchk("latch3", 4'h3, 32'h0a);
    // latch bytes read back what was written, lane 0 gated
    // each latch byte rewritten only once
    for (int i = 0; i < 4; i++)
    begin
      wreg(i[3:0], 32'h5b + 32'h33 * i);
      rchk("latch_rw", i[3:0], 32'h5b + 32'h33 * i);
    end
    be <= 4'h0;
    wreg(4'h0, 32'h00);
    be <= 4'hf;
    rchk("latch_be", 4'h0, 32'h5b);
    wreg(4'hb, 32'hff);
    rchk("unmapped", 4'hb, 32'h0);
    rchk("ctrl", npb_pkg::IDX_CTRL, 32'h0);
    wreg(npb_pkg::IDX_PROT_ROW, 32'h05);
    wreg(npb_pkg::IDX_PROT_LVL, 32'h02);
    rchk("lvl_closed", npb_pkg::IDX_PROT_LVL, 32'h0);
    rchk("status", npb_pkg::IDX_STATUS, 32'h08);
    wreg(npb_pkg::IDX_STATUS, 32'h08);
    wreg(npb_pkg::IDX_CTRL, 32'h01);
    rchk("status", npb_pkg::IDX_STATUS, 32'h01);
    for (int l = 0; l < 4; l++)
    begin
      wreg(npb_pkg::IDX_PROT_ROW, l + 1);
      wreg(npb_pkg::IDX_PROT_LVL, l);
    end
    wreg(npb_pkg::IDX_CTRL, 32'h02);
    wreg(npb_pkg::IDX_PROT_ROW, 32'h01);
    wreg(npb_pkg::IDX_PROT_LVL, 32'h03);
    wreg(npb_pkg::IDX_STATUS, 32'h08);
    for (int l = 0; l < 4; l++)
    begin
      wreg(npb_pkg::IDX_PROT_ROW, l + 1);
      rchk("row_level", npb_pkg::IDX_PROT_LVL, l);
      for (int k = 0; k < 4; k++)
      begin
        acc(k[1], k[0], {8'(l + 1), 8'h40 + 8'(k)});
        ok = (l == 0) || (l == 1 && !(k[1] && !k[0])) ||
             (l == 2 && !k[1]) || (l == 3 && k == 0);
        e_rd = (ok && !k[0]) ? (8'(l + 1) ^ (8'h40 + 8'(k)) ^ 8'h3c) : 8'h0;
        exp_wr = exp_wr + 16'(ok && k[0]);
        chk("acc_done", 32'h1, g_done);
        chk("acc_grant", ok, g_grant);
        chk("acc_rdata", e_rd, g_rdata);
      end
    end
    chk("flash_writes", exp_wr, wr_cnt);
    // fill and write one eeprom row
    for (int k = 0; k < 16; k++)
    begin
      wreg(npb_pkg::IDX_EE_ADDR, 32'h7f0 + k);
      wreg(npb_pkg::IDX_EE_BUF, (32'h11 * k) ^ 32'h5a);
    end
    wreg(npb_pkg::IDX_CTRL, 32'h08);
    wreg(npb_pkg::IDX_CTRL, 32'h08);
    acc(1'b0, 1'b0, 16'h0010);
    chk("acc_busy", 32'h1, g_done);
    rchk("status_busy", npb_pkg::IDX_STATUS, 32'h14);
    repeat (20) @(posedge clk);
    rchk("status_idle", npb_pkg::IDX_STATUS, 32'h10);
    for (int k = 0; k < 16; k++)
    begin
      wreg(npb_pkg::IDX_EE_ADDR, 32'h7f0 + k);
      rchk("ee_byte", npb_pkg::IDX_EE_DATA,
           ((32'h11 * k) ^ 32'h5a) & 32'hff);
    end
    wreg(npb_pkg::IDX_CTRL, 32'h04);
    rchk("status_sec", npb_pkg::IDX_STATUS, 32'h12);
    chk("debug_off", 32'h3, dbg);
    chk("test_off", 32'h0, test_en);
    acc(1'b1, 1'b0, 16'h0000);
    chk("sec_ext", 32'h0, {g_grant, g_rdata});
    acc(1'b0, 1'b0, 16'h0000);
    chk("sec_int", 32'h13c, {g_grant, g_rdata});
    end_sim();
  end
endmodule : tb_npb_top
